/* hw/timer16_pkg.sv */
package timer16_pkg;

    // ==========================================================
    // Mode field codes (three bits)
    // ==========================================================
    localparam logic [2:0] MODE_STOP      = 3'h0;
    localparam logic [2:0] MODE_PWM       = 3'h1;
    localparam logic [2:0] MODE_FREE_A    = 3'h2;
    localparam logic [2:0] MODE_FREE_B    = 3'h3;
    localparam logic [2:0] MODE_EDGE_A    = 3'h4;
    localparam logic [2:0] MODE_EDGE_B    = 3'h5;
    localparam logic [2:0] MODE_MATCH_A   = 3'h6;
    localparam logic [2:0] MODE_MATCH_B   = 3'h7;

    // ==========================================================
    // Count clock select codes
    // ==========================================================
    localparam logic [2:0] CLK_PIN        = 3'h0;
    localparam logic [2:0] CLK_DIV1       = 3'h1;
    localparam logic [2:0] CLK_DIV2       = 3'h2;
    localparam logic [2:0] CLK_DIV4       = 3'h3;
    localparam logic [2:0] CLK_DIV8       = 3'h4;
    localparam logic [2:0] CLK_WATCH      = 3'h7;

    // ==========================================================
    // Edge select and field positions
    // ==========================================================
    localparam logic [1:0] EDGE_FALL      = 2'h0;
    localparam logic [1:0] EDGE_RISE      = 2'h1;
    localparam logic [1:0] EDGE_BOTH      = 2'h3;
    localparam int         OUT_EN_POS     = 0;
    localparam int         OUT_LVL_POS    = 1;
    localparam int         PWM_FINE_LSB   = 2;
    localparam int         PWM_BASE_BITS  = 8;
    localparam int         PWM_SUB_BITS   = 6;
    localparam int         SCS_WIDTH      = 2;
    localparam int         PRESC_WIDTH    = 3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] CNT_RST       = 16'h0000;

    // Configuration bundle
    typedef struct packed {
        logic [2:0]           mode;
        logic [2:0]           clk_sel;
        logic                 osc_div_mode;
        logic [1:0]           edge_sel;
        logic [SCS_WIDTH-1:0] sample_clk_sel;
        logic [1:0]           out_ctrl;
    } cfg_t;

    typedef struct packed {
        logic       match_irq_primary;
        logic       ext_irq_a;
        logic       cap_valid;
    } evt_t;

endpackage

/* hw/edge_filter.sv */
module edge_filter
    import timer16_pkg::*;
(
    input  wire logic                 mclk_in,        // System clock
    input  wire logic                 arst_n_in,      // Async reset
    input  wire logic                 pin_in,         // Raw input pin
    input  wire logic                 sample_en_in,   // Sampling strobe
    input  wire logic [1:0]           edge_sel_in,    // Valid edge select
    output logic                      level_out,      // Filtered level
    output logic                      edge_out        // Valid edge pulse
);

    // ==========================================================
    // Three-stage synchroniser and sampled filter
    // ==========================================================
    logic [2:0] sync_q,   sync_d;
    logic       samp_q,   samp_d;
    logic       level_q,  level_d;
    logic       edge_q,   edge_d;
    logic       rise;
    logic       fall;

    // Stable sample needs two agreeing samples before level moves
    always_comb
    begin
        sync_d  = {sync_q[1:0], pin_in};
        samp_d  = samp_q;
        level_d = level_q;
        rise    = 1'b0;
        fall    = 1'b0;
        if (sample_en_in && (sync_q[1] == sync_q[2]))
        begin
            samp_d = sync_q[2];
            if (samp_q == sync_q[2] && level_q != sync_q[2])   // RQ17
            begin
                level_d = sync_q[2];
                rise    = sync_q[2];
                fall    = ~sync_q[2];
            end
        end
        case (edge_sel_in)                                     // RQ16
            EDGE_FALL: edge_d = fall;
            EDGE_RISE: edge_d = rise;
            EDGE_BOTH: edge_d = rise | fall;
            default:   edge_d = 1'b0;
        endcase
    end

    // Registers only
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sync_q  <= 3'h0;
            samp_q  <= 1'b0;
            level_q <= 1'b0;
            edge_q  <= 1'b0;
        end
        else
        begin
            sync_q  <= sync_d;
            samp_q  <= samp_d;
            level_q <= level_d;
            edge_q  <= edge_d;
        end
    end

    assign level_out = level_q;
    assign edge_out  = edge_q;

endmodule

/* hw/timer16.sv */
// Function
// RQ1: Count clock from pin, prescaler or watch
// RQ2: Interval period is compare plus one
// RQ3: Match clears counter and raises interrupt
// RQ4: Mode field selects stop, PWM, free, clears
// RQ5: PWM width from upper fourteen compare bits
// RQ6: Output control bit one sets active level
// RQ7: Eight-bit base cycle, fourteen-bit subcycle; the code uses a six-bit subcycle index
// RQ8: Output enable bit gates the pin
// RQ9: Software sets PWM mode before compare
// RQ10: Software keeps compare low two bits zero
// RQ11: Software avoids PWM with pin clock
// RQ12: Pulse generator period and width registers
// RQ13: Software keeps secondary below primary
// RQ14: Period primary plus one, width secondary plus one
// RQ15: Free-run edge captures count, raises interrupt
// RQ16: Capture edge rising, falling or both
// RQ17: Sampled input, two agreeing samples needed
// RQ18: Free-run capture and restart capture methods
// RQ19: Generator output set at zero, cleared on match
module timer16
    import timer16_pkg::*;
#(
    parameter int CNT_WIDTH = 16               // Counter width
)
(
    input  wire logic                 mclk_in,           // 40 MHz clock
    input  wire logic                 arst_n_in,         // Async reset
    input  wire cfg_t                 cfg_in,            // Configuration
    input  wire logic [15:0]          cmp_primary_in,    // Primary compare
    input  wire logic [15:0]          cmp_secondary_in,  // Secondary cmp
    input  wire logic                 sec_is_capture_in, // Secondary capt
    input  wire logic                 timer_in_a,        // Input pin A
    input  wire logic                 watch_tick_in,     // Watch timer
    output logic [15:0]               count_reg_out,     // Counter value
    output logic [15:0]               cmp_cap_secondary_out, // Capt value
    output logic                      timer_out_pin_out, // Timer output
    output evt_t                      evt_out            // Event pulses
);

    // ==========================================================
    // Prescaler and count enable
    // ==========================================================
    logic [PRESC_WIDTH-1:0] presc_q,   presc_d;
    logic [3:0]             samp_div_q, samp_div_d;
    logic                   watch_q,   watch_d;
    logic                   cnt_en;
    logic                   samp_en;
    logic                   pin_edge;
    logic                   pin_level;

    // Main clock stands for the oscillator; the divide-by-two
    // oscillator mode halves the DIV2, DIV4 and DIV8 taps and stops DIV1
    always_comb
    begin
        presc_d    = presc_q + PRESC_WIDTH'(1);
        samp_div_d = samp_div_q + 4'h1;
        watch_d    = watch_tick_in;
        samp_en    = 1'b0;
        case (cfg_in.sample_clk_sel)
            2'h0:    samp_en = 1'b1;
            2'h1:    samp_en = (samp_div_q[1:0] == 2'h3);
            2'h2:    samp_en = (samp_div_q[2:0] == 3'h7);
            default: samp_en = (samp_div_q == 4'hF);
        endcase
        cnt_en = 1'b0;
        case (cfg_in.clk_sel)                               // RQ1
            CLK_PIN:   cnt_en = pin_edge;
            CLK_DIV1:  cnt_en = ~cfg_in.osc_div_mode
                                & presc_q[0];
            CLK_DIV2:  cnt_en = cfg_in.osc_div_mode
                                ? presc_q[0]
                                : (presc_q[1:0] == 2'h3);
            CLK_DIV4:  cnt_en = cfg_in.osc_div_mode
                                ? (presc_q[1:0] == 2'h3)
                                : (presc_q == 3'h7);
            CLK_DIV8:  cnt_en = cfg_in.osc_div_mode
                                ? (presc_q == 3'h7)
                                : (presc_q == 3'h7)
                                  & samp_div_q[3];  // Every 16 cycles
            CLK_WATCH: cnt_en = watch_tick_in & ~watch_q;
            default:   cnt_en = 1'b0;               // Prohibited
        endcase
    end

    // Prescaler registers
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            presc_q    <= '0;
            samp_div_q <= 4'h0;
            watch_q    <= 1'b0;
        end
        else
        begin
            presc_q    <= presc_d;
            samp_div_q <= samp_div_d;
            watch_q    <= watch_d;
        end
    end

    // ==========================================================
    // Input filter
    // ==========================================================
    edge_filter u_filt
    (
        .mclk_in      (mclk_in),
        .arst_n_in    (arst_n_in),
        .pin_in       (timer_in_a),
        .sample_en_in (samp_en),
        .edge_sel_in  (cfg_in.edge_sel),
        .level_out    (pin_level),
        .edge_out     (pin_edge)
    );

    // ==========================================================
    // Mode state machine
    // ==========================================================
    typedef enum logic [3:0] {
        ST_STOP  = 4'h1,
        ST_PWM   = 4'h2,
        ST_FREE  = 4'h4,
        ST_CLEAR = 4'h8
    } state_t;

    state_t state_q, state_d;

    // Mode field decode
    always_comb
    begin
        case (cfg_in.mode)                                  // RQ4
            MODE_STOP:                 state_d = ST_STOP;
            MODE_PWM:                  state_d = ST_PWM;
            MODE_FREE_A, MODE_FREE_B:  state_d = ST_FREE;
            default:                   state_d = ST_CLEAR;
        endcase
    end

    // State register
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            state_q <= ST_STOP;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // Counter, capture and events
    // ==========================================================
    logic [CNT_WIDTH-1:0] cnt_q, cnt_d;
    logic [15:0]          cap_q, cap_d;
    evt_t                 evt_q, evt_d;
    logic                 match_p;
    logic                 match_s;
    logic                 edge_clear;
    logic                 match_clear;

    // Count clock edge counts only while a mode runs
    always_comb
    begin
        match_p     = (16'(cnt_q) == cmp_primary_in);
        match_s     = (16'(cnt_q) == cmp_secondary_in);
        edge_clear  = (state_q == ST_CLEAR) && !cfg_in.mode[1]
                      && pin_edge;                          // RQ18
        match_clear = (state_q == ST_CLEAR) && cfg_in.mode[1]
                      && cnt_en && match_p;                 // RQ3
        cnt_d       = cnt_q;
        cap_d       = cap_q;
        evt_d       = '0;
        case (state_q)
            ST_STOP:  cnt_d = '0;                           // RQ4
            ST_PWM:   cnt_d = cnt_en ? cnt_q + CNT_WIDTH'(1) : cnt_q;
            ST_FREE:  cnt_d = cnt_en ? cnt_q + CNT_WIDTH'(1) : cnt_q;
            ST_CLEAR:
            begin
                if (match_clear || edge_clear)
                    cnt_d = '0;                             // RQ2
                else if (cnt_en)
                    cnt_d = cnt_q + CNT_WIDTH'(1);
            end
            default:  cnt_d = '0;
        endcase
        // Capture on a valid edge, counter running
        if (state_q != ST_STOP && sec_is_capture_in && pin_edge)
        begin
            cap_d           = 16'(cnt_q);                   // RQ15
            evt_d.cap_valid = 1'b1;
        end
        if (state_q != ST_STOP && pin_edge)
            evt_d.ext_irq_a = 1'b1;                         // RQ15
        if (state_q != ST_STOP && state_q != ST_PWM && cnt_en
            && match_p)
            evt_d.match_irq_primary = 1'b1;                 // RQ3
    end

    // Counter registers
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_q <= '0;
            cap_q <= CNT_RST;
            evt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            cap_q <= cap_d;
            evt_q <= evt_d;
        end
    end

    // ==========================================================
    // Output generation
    // ==========================================================
    logic [PWM_SUB_BITS-1:0] sub_idx;
    logic [PWM_BASE_BITS-1:0] base_pos;
    logic [PWM_BASE_BITS-1:0] coarse;
    logic [PWM_SUB_BITS-1:0]  fine;
    logic [PWM_SUB_BITS-1:0]  sub_rev;
    logic                     extra;
    logic                     pwm_act;
    logic                     ppg_q, ppg_d;
    logic                     pin_q, pin_d;

    // Spreading the fine bits over the subcycle lets the filter
    // run with a shorter time constant than a plain 14-bit ramp
    always_comb
    begin
        base_pos = cnt_q[PWM_BASE_BITS-1:0];                // RQ7
        sub_idx  = cnt_q[PWM_BASE_BITS +: PWM_SUB_BITS];
        coarse   = cmp_primary_in[15 -: PWM_BASE_BITS];     // RQ5
        fine     = cmp_primary_in[PWM_FINE_LSB +: PWM_SUB_BITS];
        sub_rev  = {<<{sub_idx}};
        extra    = (fine > sub_rev);                        // RQ7
        pwm_act  = ({1'b0, base_pos} <
                    ({1'b0, coarse} + {8'h00, extra}));
        ppg_d    = ppg_q;
        if (state_q == ST_STOP)
            ppg_d = 1'b0;
        // Set as the counter lands on zero, in step with the match clear
        else if (16'(cnt_d) == 16'h0000)
            ppg_d = 1'b1;                                   // RQ19
        else if (cnt_en && match_s)
            ppg_d = 1'b0;                                   // RQ14
        if (state_q == ST_PWM)                              // RQ6
            pin_d = pwm_act ^ ~cfg_in.out_ctrl[OUT_LVL_POS];
        else
            pin_d = ppg_q ^ ~cfg_in.out_ctrl[OUT_LVL_POS];  // RQ12
        if (!cfg_in.out_ctrl[OUT_EN_POS])
            pin_d = 1'b0;                                   // RQ8
    end

    // Output registers
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ppg_q <= 1'b0;
            pin_q <= 1'b0;
        end
        else
        begin
            ppg_q <= ppg_d;
            pin_q <= pin_d;
        end
    end

    // Every output comes from a flip-flop
    assign count_reg_out         = 16'(cnt_q);
    assign cmp_cap_secondary_out = cap_q;
    assign timer_out_pin_out     = pin_q;
    assign evt_out               = evt_q;

endmodule

/* tb/timer16_asserts.sv */
module timer16_asserts
    import timer16_pkg::*;
(
    input wire logic        mclk_in,               // Clock
    input wire logic        arst_n_in,             // Reset
    input wire cfg_t        cfg_in,                // Configuration
    input wire logic [15:0] cmp_primary_in,        // Primary compare
    input wire logic [15:0] cmp_secondary_in,      // Secondary compare
    input wire logic        sec_is_capture_in,     // Capture select
    input wire logic        timer_in_a,            // Input pin A
    input wire logic        watch_tick_in,         // Watch tick
    input wire logic [15:0] count_reg_out,         // Counter
    input wire logic [15:0] cmp_cap_secondary_out, // Captured value
    input wire logic        timer_out_pin_out,     // Output pin
    input wire evt_t        evt_out                // Event pulses
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic        int_cfg;
    logic        ppg_cfg;
    logic [17:0] gap_q;
    logic [17:0] gap_d;
    logic        seen_q;
    logic        seen_d;

    // Half-rate clock in match modes gives an exact spacing to compare
    assign int_cfg = cfg_in.mode[2:1] == 2'b11 && !cfg_in.osc_div_mode
                     && cfg_in.clk_sel == CLK_DIV1;
    assign ppg_cfg = int_cfg && cfg_in.out_ctrl == 2'h3
                     && !sec_is_capture_in && cmp_secondary_in != 16'h0;

    // Cycles since last match request; first gap after start is skipped
    always_comb
    begin
        gap_d  = evt_out.match_irq_primary ? 18'h0 : gap_q + 18'h1;
        seen_d = int_cfg && (seen_q || evt_out.match_irq_primary);
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            gap_q  <= 18'h0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= gap_d;
            seen_q <= seen_d;
        end
    end

    // ==========
    // Sequences and checks
    sequence s_stopped;
        cfg_in.mode == MODE_STOP [*3];
    endsequence
    sequence s_gen_start;
        ppg_cfg && seen_q && count_reg_out == 16'h1;
    endsequence

    chk_stop_zero: assert property (
        s_stopped |-> count_reg_out == CNT_RST)
        else $error("counter not zero while stopped");
    chk_match_clear: assert property (
        evt_out.match_irq_primary && cfg_in.mode[2:1] == 2'b11
        |-> count_reg_out <= 16'h1)
        else $error("counter not cleared on match");
    chk_irq_single: assert property (
        evt_out.match_irq_primary |=> !evt_out.match_irq_primary)
        else $error("match request longer than one cycle");
    chk_interval_gap: assert property (
        evt_out.match_irq_primary && seen_q && int_cfg
        |-> gap_q + 18'h1 == {1'b0, cmp_primary_in, 1'b0} + 18'h2)
        else $error("interval spacing wrong");
    chk_capture_near: assert property (
        evt_out.ext_irq_a && sec_is_capture_in && cfg_in.mode == MODE_FREE_A
        |-> count_reg_out - cmp_cap_secondary_out <= 16'h2)
        else $error("captured value far from counter");
    chk_rise_level: assert property (
        evt_out.ext_irq_a && cfg_in.edge_sel == EDGE_RISE |-> timer_in_a)
        else $error("rise request with pin low");
    chk_fall_level: assert property (
        evt_out.ext_irq_a && cfg_in.edge_sel == EDGE_FALL |-> !timer_in_a)
        else $error("fall request with pin high");
    chk_out_hold: assert property (
        !cfg_in.out_ctrl[OUT_EN_POS] [*3] |-> $stable(timer_out_pin_out))
        else $error("pin moved while output disabled");
    chk_gen_high: assert property (
        s_gen_start |-> timer_out_pin_out)
        else $error("generator not active after restart");
    chk_gen_low: assert property (
        ppg_cfg && count_reg_out > cmp_secondary_in + 16'h1
        |-> !timer_out_pin_out)
        else $error("generator active past secondary match");
endmodule

bind timer16 timer16_asserts i_chk
(
    .mclk_in               (mclk_in),
    .arst_n_in             (arst_n_in),
    .cfg_in                (cfg_in),
    .cmp_primary_in        (cmp_primary_in),
    .cmp_secondary_in      (cmp_secondary_in),
    .sec_is_capture_in     (sec_is_capture_in),
    .timer_in_a            (timer_in_a),
    .watch_tick_in         (watch_tick_in),
    .count_reg_out         (count_reg_out),
    .cmp_cap_secondary_out (cmp_cap_secondary_out),
    .timer_out_pin_out     (timer_out_pin_out),
    .evt_out               (evt_out)
);

/* tb/pulse_src.sv */
module pulse_src
(
    input  wire logic mclk_in,   // Bench clock
    output logic      pin_out,   // External pulse line
    output logic      watch_out  // Watch timer level
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both lines idle low
    initial
    begin
        pin_out   = 1'b0;
        watch_out = 1'b0;
    end

    // Pulse then idle gap; short widths act as noise
    task automatic pulse(input int width, input int gap);
        @(negedge mclk_in);
        pin_out = 1'b1;
        repeat (width) @(negedge mclk_in);
        pin_out = 1'b0;
        repeat (gap) @(negedge mclk_in);
    endtask

    // Watch output far slower than the main clock
    task automatic ticks(input int n);
        repeat (n)
        begin
            repeat (8) @(negedge mclk_in);
            watch_out = 1'b1;
            repeat (8) @(negedge mclk_in);
            watch_out = 1'b0;
        end
    endtask
endmodule

/* tb/timer16_tb.sv */
module timer16_tb
    import timer16_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_in;
    logic        arst_n_in;
    cfg_t        cfg_in;
    logic [15:0] cmp_primary_in;
    logic [15:0] cmp_secondary_in;
    logic        sec_is_capture_in;
    logic        timer_in_a;
    logic        watch_tick_in;
    logic [15:0] count_reg_out;
    logic [15:0] cmp_cap_secondary_out;
    logic        timer_out_pin_out;
    evt_t        evt_out;
    logic        osc;
    logic [1:0]  edges [3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
    int          fail_count, cmp_count, seed, n, m, k, hi, ext_cnt;
    int          cap_cnt;

    timer16 #(.CNT_WIDTH(16)) i_dut
    (
        .mclk_in               (mclk_in),
        .arst_n_in             (arst_n_in),
        .cfg_in                (cfg_in),
        .cmp_primary_in        (cmp_primary_in),
        .cmp_secondary_in      (cmp_secondary_in),
        .sec_is_capture_in     (sec_is_capture_in),
        .timer_in_a            (timer_in_a),
        .watch_tick_in         (watch_tick_in),
        .count_reg_out         (count_reg_out),
        .cmp_cap_secondary_out (cmp_cap_secondary_out),
        .timer_out_pin_out     (timer_out_pin_out),
        .evt_out               (evt_out)
    );
    pulse_src i_src
    (
        .mclk_in   (mclk_in),
        .pin_out   (timer_in_a),
        .watch_out (watch_tick_in)
    );

    // ==========
    // Clock, watchdog, capture request tally
    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    initial
    begin
        #(25 * 100000);
        fail_count++;
        wrap_up();
    end
    always @(negedge mclk_in)
    begin
        if (evt_out.ext_irq_a === 1'b1) ext_cnt++;
        if (evt_out.cap_valid === 1'b1) cap_cnt++;
    end

    // ==========
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Config only changes while stopped, so stop first
    task automatic start(input logic [2:0] md, input logic [2:0] cs,
        input logic [1:0] es, input logic [1:0] ss, input logic [1:0] oc,
        input int p, input int s);
        @(negedge mclk_in);
        cfg_in.mode = MODE_STOP;
        repeat (3) @(negedge mclk_in);
        cfg_in = '{MODE_STOP, cs, osc, es, ss, oc};
        cmp_primary_in = p[15:0];
        cmp_secondary_in = s[15:0];
        @(negedge mclk_in);
        cfg_in.mode = md;
        ext_cnt = 0;
        cap_cnt = 0;
    endtask
    // Bounded wait for a match request or an output pin level
    task automatic wait_on(input logic irq, input logic v);
        k = 0;
        do
        begin
            @(negedge mclk_in);
            k++;
        end
        while ((irq ? evt_out.match_irq_primary : timer_out_pin_out) !== v
               && k < 500);
    endtask

    // ==========
    // Scenarios
    initial
    begin
        seed = 74592;
        fail_count = 0;
        cmp_count = 0;
        ext_cnt = 0;
        osc = 1'b0;
        arst_n_in = 1'b0;
        cfg_in = '0;
        cmp_primary_in = 16'h0;
        cmp_secondary_in = 16'h0;
        sec_is_capture_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        arst_n_in = 1'b1;
        // Interval spacing, smallest compare first
        for (int i = 0; i < 4; i++)
        begin
            n = (i == 0) ? 1 : 2 + $unsigned($random(seed)) % 40;
            start(MODE_MATCH_A, CLK_DIV1, EDGE_RISE, 2'h0, 2'h0, n, 0);
            wait_on(1'b1, 1'b1);
            wait_on(1'b1, 1'b1);
            check(k, 2 * (n + 1));
        end
        // Slower dividers count less; prohibited codes never count
        hi = 1000;
        for (int c = 1; c < 7; c++)
        begin
            start(MODE_FREE_A, c[2:0], EDGE_RISE, 2'h0, 2'h0, 16'hFFFF, 0);
            repeat (160) @(negedge mclk_in);
            check(c < 5 ? count_reg_out < hi && count_reg_out > 0
                        : count_reg_out == 0, 1);
            hi = count_reg_out;
        end
        osc = 1'b1;
        start(MODE_FREE_A, CLK_DIV1, EDGE_RISE, 2'h0, 2'h0, 16'hFFFF, 0);
        repeat (50) @(negedge mclk_in);
        check(count_reg_out, 0);
        osc = 1'b0;
        start(MODE_FREE_A, CLK_WATCH, EDGE_RISE, 2'h0, 2'h0, 16'hFFFF, 0);
        i_src.ticks(5);
        check(count_reg_out, 5);
        start(MODE_FREE_A, CLK_PIN, EDGE_RISE, 2'h0, 2'h0, 16'hFFFF, 0);
        repeat (6) i_src.pulse(30, 30);
        check(count_reg_out, 6);
        // Capture on every edge code and sampling rate, glitch at slowest
        for (int e = 0; e < 3; e++)
            for (int s = 0; s < 4; s++)
            begin
                start(MODE_FREE_A, CLK_DIV1, edges[e], s[1:0], 2'h0,
                      16'hFFFF, 0);
                repeat (3) i_src.pulse(60, 60);
                if (s == 3) i_src.pulse(2, 60);
                check(ext_cnt, e == 2 ? 6 : 3);
                check(cap_cnt, ext_cnt);
            end
        // Restart capture: rises 121 cycles apart, count every 2 cycles
        start(MODE_EDGE_A, CLK_DIV1, EDGE_RISE, 2'h0, 2'h0, 16'hFFFF, 0);
        repeat (3) i_src.pulse(60, 60);
        check(cmp_cap_secondary_out, 60);
        // Generator period and width, secondary below primary
        sec_is_capture_in = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            n = 4 + $unsigned($random(seed)) % 30;
            m = 1 + $unsigned($random(seed)) % (n - 1);
            start(MODE_MATCH_A, CLK_DIV1, EDGE_RISE, 2'h0, 2'h3, n, m);
            // First period after start is skipped: it begins off phase
            wait_on(1'b1, 1'b1);
            wait_on(1'b0, 1'b1);
            wait_on(1'b0, 1'b0);
            hi = k;
            wait_on(1'b0, 1'b1);
            check(hi, 2 * (m + 1));
            check(hi + k, 2 * (n + 1));
        end
        // PWM duty over all 64 sub-cycles of a full cycle, both active levels
        n = $unsigned($random(seed)) % 16384;
        for (int lv = 1; lv >= 0; lv--)
        begin
            start(MODE_PWM, CLK_DIV1, EDGE_RISE, 2'h0, {lv[0], 1'b1}, 0, 0);
            @(negedge mclk_in);
            cmp_primary_in = {n[13:0], 2'b00};
            repeat (600) @(negedge mclk_in);
            hi = 0;
            repeat (32768)
            begin
                @(negedge mclk_in);
                hi += (timer_out_pin_out === 1'b1);
            end
            check(hi, lv ? 2 * n : 32768 - 2 * n);
        end
        wrap_up();
    end
endmodule
